// [design/sfd_cfg.svh]
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH

// dedicated wide-address opcodes
`define SFD_OP_PLAIN_READ_WIDE_ADDR 8'h13
`define SFD_OP_QUICK_READ_WIDE_ADDR 8'h0c
`define SFD_OP_DUAL_OUT_READ_WIDE_ADDR 8'h3c
`define SFD_OP_QUAD_OUT_READ_WIDE_ADDR 8'h6c
`define SFD_OP_DUAL_IO_READ_WIDE_ADDR 8'hbc
`define SFD_OP_QUAD_IO_READ_WIDE_ADDR 8'hec
`define SFD_OP_DOUBLE_RATE_QUICK_READ_WIDE 8'h0e
`define SFD_OP_DOUBLE_RATE_DUAL_IO_WIDE 8'hbe
`define SFD_OP_DOUBLE_RATE_QUAD_IO_WIDE 8'hee
`define SFD_OP_PAGE_WRITE_WIDE_ADDR 8'h12
`define SFD_OP_QUAD_PAGE_WRITE_WIDE_ADDR 8'h34
`define SFD_OP_SMALL_SECTOR_ERASE_WIDE 8'h21
`define SFD_OP_SECTOR_ERASE_WIDE_ADDR 8'hdc

// legacy opcodes, width follows the wide address enable
`define SFD_OP_PLAIN_ARRAY_READ 8'h03
`define SFD_OP_QUICK_ARRAY_READ 8'h0b
`define SFD_OP_DUAL_OUT_ARRAY_READ 8'h3b
`define SFD_OP_QUAD_OUT_ARRAY_READ 8'h6b
`define SFD_OP_DUAL_IO_ARRAY_READ 8'hbb
`define SFD_OP_QUAD_IO_ARRAY_READ 8'heb
`define SFD_OP_DOUBLE_RATE_QUICK_READ 8'h0d
`define SFD_OP_DOUBLE_RATE_DUAL_IO_READ 8'hbd
`define SFD_OP_DOUBLE_RATE_QUAD_IO_READ 8'hed
`define SFD_OP_PAGE_WRITE 8'h02
`define SFD_OP_QUAD_PAGE_WRITE 8'h32
`define SFD_OP_QUAD_PAGE_WRITE_ALT 8'h38
`define SFD_OP_SMALL_SECTOR_ERASE 8'h20
`define SFD_OP_SECTOR_ERASE 8'hd8

// identification and register access
`define SFD_OP_MAKER_SIGNATURE_READ 8'h90
`define SFD_OP_IDENTIFICATION_READ 8'h9f
`define SFD_OP_SIGNATURE_READ 8'hab
`define SFD_OP_STATUS_ONE_READ 8'h05
`define SFD_OP_STATUS_TWO_READ 8'h07
`define SFD_OP_CONFIG_ONE_READ 8'h35
`define SFD_OP_STATUS_CONFIG_WRITE 8'h01
`define SFD_OP_WRITE_DISABLE_CMD 8'h04
`define SFD_OP_WRITE_ENABLE_CMD 8'h06
`define SFD_OP_FAIL_STATUS_CLEAR 8'h30
`define SFD_OP_BANK_SELECT_READ 8'h16
`define SFD_OP_BANK_SELECT_WRITE 8'h17
`define SFD_OP_BANK_SELECT_LEGACY_ACCESS 8'hb9
`define SFD_OP_LEARNING_PATTERN_READ 8'h41
`define SFD_OP_LEARNING_PATTERN_NV_WRITE 8'h43
`define SFD_OP_LEARNING_PATTERN_VOL_WRITE 8'h4a

// bank select register layout
`define SFD_BANK_RST 8'h00
`define SFD_BANK_WIDE_BIT 7
`define SFD_BANK_WMASK 8'h83
`define SFD_BANK_SEL_MASK 8'h03

// shift counts
`define SFD_OPC_LAST 6'h07
`define SFD_BYTE_LAST 3'h7
`define SFD_ADDR_BITS_WIDE 6'h20
`define SFD_ADDR_BITS_NARROW 6'h18

`endif

// [design/sfd_pkg.sv]
package sfd_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_OPC = 5'h02,
    ST_ADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_SKIP = 5'h10
  } sfd_st_t;

  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_READ = 4'h1,
    CLS_PROG = 4'h2,
    CLS_ERASE = 4'h3,
    CLS_IDENT = 4'h4,
    CLS_STAT_RD = 4'h5,
    CLS_REG_WR = 4'h6,
    CLS_BANK_RD = 4'h7,
    CLS_BANK_WR = 4'h8,
    CLS_LEARN = 4'h9
  } sfd_cls_t;

  typedef struct packed {
    sfd_cls_t cls;
    logic hasAddr;
    logic fixedWide;
  } sfd_dec_t;

  typedef struct packed {
    logic [7:0] opcode;
    sfd_cls_t cls;
    logic wide;
    logic [31:0] addr;
  } sfd_cmd_t;

  typedef struct packed {
    sfd_st_t st;
    logic [2:0] csSync;
    logic [2:0] sckSync;
    logic [2:0] siSync;
    logic csF;
    logic sckF;
    logic siF;
    logic sckPrev;
    logic [5:0] bitCnt;
    logic [31:0] shift;
    logic [7:0] opcode;
    sfd_cls_t cls;
    logic wide;
    logic [7:0] bank;
    logic [31:0] curAddr;
    logic so;
    logic soOe;
    logic pend;
    sfd_cmd_t pendCmd;
    logic outValid;
    sfd_cmd_t outCmd;
    logic overflow;
  } sfd_state_t;

endpackage

// [design/sfd_fifo.sv]
`timescale 1ns/100ps
module sfd_fifo
  import sfd_pkg::*;
#(
  parameter int WIDTH = 45,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sfd_fifo_st_t;

  sfd_fifo_st_t fs_ff;
  sfd_fifo_st_t nxt_fs;
  logic full;
  logic empty;

  assign empty = (fs_ff.wr == fs_ff.rd);
  assign full = (fs_ff.wr[AW] != fs_ff.rd[AW]) &&
                (fs_ff.wr[AW-1:0] == fs_ff.rd[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = fs_ff.mem[fs_ff.rd[AW-1:0]];

  always_comb
  begin
    nxt_fs = fs_ff;
    if (inValid && !full)
    begin
      nxt_fs.mem[fs_ff.wr[AW-1:0]] = inData;
      nxt_fs.wr = fs_ff.wr + (AW+1)'(1);
    end
    if (outReady && !empty)
      nxt_fs.rd = fs_ff.rd + (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fs_ff <= '0;
    else
      fs_ff <= nxt_fs;
  end
endmodule

// [design/sfd_decoder.sv]
`timescale 1ns/100ps
`include "sfd_cfg.svh"
module sfd_decoder
  import sfd_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial pins
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soOe,
  // decoded command stream
  output logic cmdValid,
  input wire logic cmdReady,
  output sfd_cmd_t cmdWord,
  output logic cmdOverflow,
  // status
  output logic [7:0] bankSel,
  output logic [31:0] curAddr,
  output logic dataPhase
);
  sfd_state_t st_ff;
  sfd_state_t nxt_st;
  sfd_dec_t dec;
  sfd_cmd_t pushCmd;
  sfd_cmd_t fifoOut;
  logic doPush;
  logic sckRise;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [7:0] opcNext;
  logic [31:0] addrNext;
  logic [5:0] addrLast;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  function automatic sfd_dec_t decode(input logic [7:0] op);
    sfd_dec_t d;
    d = '{cls: CLS_NONE, hasAddr: 1'b0, fixedWide: 1'b0};
    case (op)
      `SFD_OP_PLAIN_READ_WIDE_ADDR, `SFD_OP_QUICK_READ_WIDE_ADDR,
      `SFD_OP_DUAL_OUT_READ_WIDE_ADDR,
      `SFD_OP_QUAD_OUT_READ_WIDE_ADDR:
        d = '{cls: CLS_READ, hasAddr: 1'b1, fixedWide: 1'b1};
      `SFD_OP_DUAL_IO_READ_WIDE_ADDR, `SFD_OP_QUAD_IO_READ_WIDE_ADDR,
      `SFD_OP_DOUBLE_RATE_QUICK_READ_WIDE,
      `SFD_OP_DOUBLE_RATE_DUAL_IO_WIDE,
      `SFD_OP_DOUBLE_RATE_QUAD_IO_WIDE:
        d = '{cls: CLS_READ, hasAddr: 1'b1, fixedWide: 1'b1};
      `SFD_OP_PAGE_WRITE_WIDE_ADDR,
      `SFD_OP_QUAD_PAGE_WRITE_WIDE_ADDR:
        d = '{cls: CLS_PROG, hasAddr: 1'b1, fixedWide: 1'b1};
      `SFD_OP_SMALL_SECTOR_ERASE_WIDE,
      `SFD_OP_SECTOR_ERASE_WIDE_ADDR:
        d = '{cls: CLS_ERASE, hasAddr: 1'b1, fixedWide: 1'b1};
      `SFD_OP_PLAIN_ARRAY_READ, `SFD_OP_QUICK_ARRAY_READ,
      `SFD_OP_DUAL_OUT_ARRAY_READ, `SFD_OP_QUAD_OUT_ARRAY_READ,
      `SFD_OP_DUAL_IO_ARRAY_READ, `SFD_OP_QUAD_IO_ARRAY_READ,
      `SFD_OP_DOUBLE_RATE_QUICK_READ, `SFD_OP_DOUBLE_RATE_DUAL_IO_READ,
      `SFD_OP_DOUBLE_RATE_QUAD_IO_READ:
        d = '{cls: CLS_READ, hasAddr: 1'b1, fixedWide: 1'b0};
      `SFD_OP_PAGE_WRITE, `SFD_OP_QUAD_PAGE_WRITE,
      `SFD_OP_QUAD_PAGE_WRITE_ALT:
        d = '{cls: CLS_PROG, hasAddr: 1'b1, fixedWide: 1'b0};
      `SFD_OP_SMALL_SECTOR_ERASE, `SFD_OP_SECTOR_ERASE:
        d = '{cls: CLS_ERASE, hasAddr: 1'b1, fixedWide: 1'b0};
      `SFD_OP_MAKER_SIGNATURE_READ, `SFD_OP_IDENTIFICATION_READ,
      `SFD_OP_SIGNATURE_READ:
        d.cls = CLS_IDENT;
      `SFD_OP_STATUS_ONE_READ, `SFD_OP_STATUS_TWO_READ,
      `SFD_OP_CONFIG_ONE_READ:
        d.cls = CLS_STAT_RD;
      `SFD_OP_STATUS_CONFIG_WRITE, `SFD_OP_WRITE_DISABLE_CMD,
      `SFD_OP_WRITE_ENABLE_CMD, `SFD_OP_FAIL_STATUS_CLEAR:
        d.cls = CLS_REG_WR;
      `SFD_OP_BANK_SELECT_READ:
        d.cls = CLS_BANK_RD;
      `SFD_OP_BANK_SELECT_WRITE,
      `SFD_OP_BANK_SELECT_LEGACY_ACCESS:
        d.cls = CLS_BANK_WR;
      `SFD_OP_LEARNING_PATTERN_READ, `SFD_OP_LEARNING_PATTERN_NV_WRITE,
      `SFD_OP_LEARNING_PATTERN_VOL_WRITE:
        d.cls = CLS_LEARN;
      default:
        d.cls = CLS_NONE;
    endcase
    return d;
  endfunction

  assign sckRise = st_ff.sckF & ~st_ff.sckPrev;
  assign opcNext = {st_ff.shift[6:0], st_ff.siF};
  assign addrNext = {st_ff.shift[30:0], st_ff.siF};
  assign dec = decode(opcNext);
  assign addrLast = st_ff.wide ? `SFD_ADDR_BITS_WIDE - 6'h01
                               : `SFD_ADDR_BITS_NARROW - 6'h01;
  assign fifoOutReady = !st_ff.outValid || cmdReady;

  always_comb
  begin
    nxt_st = st_ff;
    doPush = 1'b0;
    pushCmd = '0;
    // pin synchronisers and filtered levels
    nxt_st.csSync = {st_ff.csSync[1:0], csN};
    nxt_st.sckSync = {st_ff.sckSync[1:0], sck};
    nxt_st.siSync = {st_ff.siSync[1:0], si};
    if (st_ff.csSync[1] == st_ff.csSync[2])
      nxt_st.csF = st_ff.csSync[2];
    if (st_ff.sckSync[1] == st_ff.sckSync[2])
      nxt_st.sckF = st_ff.sckSync[2];
    if (st_ff.siSync[1] == st_ff.siSync[2])
      nxt_st.siF = st_ff.siSync[2];
    nxt_st.sckPrev = st_ff.sckF;
    // pending push drains into the fifo
    if (fifoInReady)
      nxt_st.pend = 1'b0;
    // registered output stage
    if (fifoOutValid && fifoOutReady)
    begin
      nxt_st.outValid = 1'b1;
      nxt_st.outCmd = fifoOut;
    end
    else if (cmdReady)
      nxt_st.outValid = 1'b0;
    case (st_ff.st)
      ST_IDLE:
      begin
        nxt_st.soOe = 1'b0;
        if (!st_ff.csF)
        begin
          nxt_st.st = ST_OPC;
          nxt_st.bitCnt = '0;
        end
      end
      ST_OPC:
      begin
        if (sckRise)
        begin
          nxt_st.shift = {st_ff.shift[30:0], st_ff.siF};
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == `SFD_OPC_LAST)
          begin
            nxt_st.opcode = opcNext;
            nxt_st.cls = dec.cls;
            nxt_st.bitCnt = '0;
            nxt_st.wide = dec.fixedWide |
                          st_ff.bank[`SFD_BANK_WIDE_BIT];
            nxt_st.shift = '0;
            if (dec.cls == CLS_NONE)
              nxt_st.st = ST_SKIP;
            else if (dec.hasAddr)
              nxt_st.st = ST_ADDR;
            else
            begin
              nxt_st.st = ST_DATA;
              doPush = 1'b1;
              pushCmd = '{opcode: opcNext, cls: dec.cls, wide: 1'b0,
                          addr: 32'h00000000};
              if (dec.cls == CLS_BANK_RD)
              begin
                nxt_st.so = st_ff.bank[7];
                nxt_st.shift = {st_ff.bank[6:0], st_ff.bank[7], 24'h000000};
              end
            end
          end
        end
      end
      ST_ADDR:
      begin
        if (sckRise)
        begin
          nxt_st.shift = addrNext;
          nxt_st.bitCnt = st_ff.bitCnt + 6'h01;
          if (st_ff.bitCnt == addrLast)
          begin
            nxt_st.st = ST_DATA;
            nxt_st.bitCnt = '0;
            doPush = 1'b1;
            pushCmd.opcode = st_ff.opcode;
            pushCmd.cls = st_ff.cls;
            pushCmd.wide = st_ff.wide;
            if (st_ff.wide)
              pushCmd.addr = addrNext;
            else
              pushCmd.addr = {st_ff.bank & `SFD_BANK_SEL_MASK,
                              addrNext[23:0]};
            nxt_st.curAddr = pushCmd.addr;
          end
        end
      end
      ST_DATA:
      begin
        nxt_st.soOe = (st_ff.cls == CLS_BANK_RD);
        // launched on the rise, settled before the next rise
        if (sckRise && st_ff.cls == CLS_BANK_RD)
        begin
          nxt_st.so = st_ff.shift[31];
          nxt_st.shift[31:24] = {st_ff.shift[30:24], st_ff.shift[31]};
        end
        if (sckRise)
        begin
          nxt_st.bitCnt = {3'h0, st_ff.bitCnt[2:0] + 3'h1};
          if (st_ff.cls != CLS_BANK_RD)
            nxt_st.shift = addrNext;
          if (st_ff.bitCnt[2:0] == `SFD_BYTE_LAST)
          begin
            if (st_ff.cls == CLS_READ || st_ff.cls == CLS_PROG)
              nxt_st.curAddr = st_ff.curAddr + 32'h1;
            if (st_ff.cls == CLS_BANK_WR)
              nxt_st.bank = addrNext[7:0] & `SFD_BANK_WMASK;
          end
        end
      end
      ST_SKIP:
        nxt_st.soOe = 1'b0;
      default:
        nxt_st.st = ST_IDLE;
    endcase
    // chip select high ends any command
    if (st_ff.csF && st_ff.st != ST_IDLE)
    begin
      nxt_st.st = ST_IDLE;
      nxt_st.soOe = 1'b0;
    end
    if (doPush)
    begin
      if (st_ff.pend && !fifoInReady)
        nxt_st.overflow = 1'b1;
      nxt_st.pend = 1'b1;
      nxt_st.pendCmd = pushCmd;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      st_ff.st <= ST_IDLE;
      st_ff.csSync <= 3'h7;
      st_ff.csF <= 1'b1;
      st_ff.bank <= `SFD_BANK_RST;
      st_ff.cls <= CLS_NONE;
      st_ff.pendCmd.cls <= CLS_NONE;
      st_ff.outCmd.cls <= CLS_NONE;
    end
    else
      st_ff <= nxt_st;
  end

  sfd_fifo #(
    .WIDTH($bits(sfd_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(st_ff.pend),
    .inReady(fifoInReady),
    .inData(st_ff.pendCmd),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  assign so = st_ff.so;
  assign soOe = st_ff.soOe;
  assign cmdValid = st_ff.outValid;
  assign cmdWord = st_ff.outCmd;
  assign cmdOverflow = st_ff.overflow;
  assign bankSel = st_ff.bank;
  assign curAddr = st_ff.curAddr;
  assign dataPhase = st_ff.st[3];

  // assertions
  sequence seq_opc_done;
    st_ff.st == ST_OPC && sckRise && st_ff.bitCnt == `SFD_OPC_LAST;
  endsequence

  sequence seq_addr_entered;
    st_ff.st == ST_OPC ##1 st_ff.st == ST_ADDR;
  endsequence

  a_opc_msb_first: assert property (
    seq_opc_done ##0 (st_ff.csF == 1'b0) |=>
      st_ff.opcode == {$past(st_ff.shift[6:0]), $past(st_ff.siF)})
    else $error("opcode not shifted msb first");

  a_fixed_wide_rd: assert property (
    seq_addr_entered ##0 (st_ff.opcode == `SFD_OP_PLAIN_READ_WIDE_ADDR ||
      st_ff.opcode == `SFD_OP_QUAD_OUT_READ_WIDE_ADDR) |-> st_ff.wide)
    else $error("wide read opcode took short address");

  a_fixed_wide_io: assert property (
    seq_addr_entered ##0 (st_ff.opcode == `SFD_OP_DOUBLE_RATE_QUAD_IO_WIDE ||
      st_ff.opcode == `SFD_OP_DUAL_IO_READ_WIDE_ADDR) |-> st_ff.wide)
    else $error("wide io opcode took short address");

  a_fixed_wide_pe: assert property (
    seq_addr_entered ##0 (st_ff.opcode == `SFD_OP_SECTOR_ERASE_WIDE_ADDR ||
      st_ff.opcode == `SFD_OP_PAGE_WRITE_WIDE_ADDR) |-> st_ff.wide)
    else $error("wide program or erase took short address");

  a_legacy_width: assert property (
    seq_addr_entered ##0 (st_ff.opcode == `SFD_OP_PLAIN_ARRAY_READ ||
      st_ff.opcode == `SFD_OP_SECTOR_ERASE) |->
      st_ff.wide == $past(st_ff.bank[`SFD_BANK_WIDE_BIT]))
    else $error("legacy width does not follow enable");

  a_bank_top_byte: assert property (
    st_ff.pend && !$past(st_ff.pend) && st_ff.pendCmd.cls == CLS_READ &&
    !st_ff.pendCmd.wide |->
      st_ff.pendCmd.addr[31:24] == (st_ff.bank & `SFD_BANK_SEL_MASK))
    else $error("short address top byte not from bank");

  a_bank_read_stable: assert property (
    st_ff.st == ST_DATA && st_ff.cls == CLS_READ |=> $stable(st_ff.bank))
    else $error("bank register changed during read");

  a_addr_increment: assert property (
    st_ff.st == ST_DATA && st_ff.cls == CLS_READ && sckRise &&
    st_ff.bitCnt[2:0] == `SFD_BYTE_LAST && !st_ff.csF |=>
      st_ff.curAddr == $past(st_ff.curAddr) + 32'h00000001)
    else $error("byte address did not increment");

  a_unknown_ignored: assert property (
    st_ff.st == ST_SKIP && !st_ff.csF |=> st_ff.st == ST_SKIP && !soOe)
    else $error("ignored command left skip state early");
endmodule

// [sim/sfd_host.sv]
`timescale 1ns/100ps
module sfd_host
  import sfd_pkg::*;
(
  // system clock
  input wire logic clk,
  // serial pins
  output logic csN,
  output logic sck,
  output logic si,
  input wire logic so
);
  // half link period, 4 clk: 400 ns sck, far below 50 mhz
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask

  // one framed command of n bits, so sampled at each sck rise
  task automatic frame(input logic [63:0] v, input int n,
    output logic [63:0] rx);
    rx = '0;
    csN = 1'b0;
    hold();
    for (int i = n - 1; i >= 0; i--)
    begin
      si = v[i];
      hold();
      sck = 1'b1;
      rx = {rx[62:0], so};
      hold();
      sck = 1'b0;
    end
    hold();
    csN = 1'b1;
    // released line never shows the last bit
    si = ~si;
    hold();
  endtask

  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
endmodule

// [sim/tb.sv]
`timescale 1ns/100ps
module tb;
  import sfd_pkg::*;
  localparam logic [7:0] FIX [13] = '{8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc,
    8'hec, 8'h0e, 8'hbe, 8'hee, 8'h12, 8'h34, 8'h21, 8'hdc};
  localparam logic [7:0] LEG [14] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb,
    8'heb, 8'h0d, 8'hbd, 8'hed, 8'h02, 8'h32, 8'h38, 8'h20, 8'hd8};
  localparam logic [7:0] MISC [13] = '{8'h90, 8'h9f, 8'hab, 8'h05, 8'h07,
    8'h35, 8'h01, 8'h04, 8'h06, 8'h30, 8'h41, 8'h43, 8'h4a};
  logic clk;
  logic nrst;
  logic csN;
  logic sck;
  logic si;
  logic so;
  logic soOe;
  logic cmdValid;
  logic cmdReady;
  sfd_cmd_t cmdWord;
  logic cmdOverflow;
  logic [7:0] bankSel;
  logic [31:0] curAddr;
  logic dataPhase;
  logic [63:0] rx;
  sfd_cmd_t w;
  int nErrors;
  int totalChecks;
  int k;

  sfd_decoder #(.FIFO_DEPTH(16)) u_dut (.clk(clk), .nrst(nrst),
    .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWord(cmdWord),
    .cmdOverflow(cmdOverflow), .bankSel(bankSel), .curAddr(curAddr),
    .dataPhase(dataPhase));

  sfd_host u_host (.clk(clk), .csN(csN), .sck(sck), .si(si), .so(so));

  always #25 clk = ~clk;

  task automatic finalReport();
    if (nErrors == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // class that each opcode must decode to
  function automatic sfd_cls_t clsOf(input logic [7:0] op);
    case (op)
      8'h12, 8'h34, 8'h02, 8'h32, 8'h38: clsOf = CLS_PROG;
      8'h21, 8'hdc, 8'h20, 8'hd8: clsOf = CLS_ERASE;
      8'h90, 8'h9f, 8'hab: clsOf = CLS_IDENT;
      8'h05, 8'h07, 8'h35: clsOf = CLS_STAT_RD;
      8'h01, 8'h04, 8'h06, 8'h30: clsOf = CLS_REG_WR;
      8'h16: clsOf = CLS_BANK_RD;
      8'h17, 8'hb9: clsOf = CLS_BANK_WR;
      8'h41, 8'h43, 8'h4a: clsOf = CLS_LEARN;
      default: clsOf = CLS_READ;
    endcase
  endfunction

  // take one word off the command stream, bounded wait
  task automatic pop(output sfd_cmd_t c);
    int n;
    n = 0;
    while (cmdValid !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 400)
    begin
      chk(1'b0, 1'b1);
      finalReport();
    end
    c = cmdWord;
    cmdReady = 1'b1;
    @(negedge clk);
    cmdReady = 1'b0;
    @(negedge clk);
  endtask

  task automatic cmdAddr(input logic [7:0] op, input logic wd,
    input logic [31:0] a, input logic [31:0] ea);
    if (wd)
      u_host.frame({24'h0, op, a}, 40, rx);
    else
      u_host.frame({32'h0, op, a[23:0]}, 32, rx);
    pop(w);
    chk(w.opcode, op);
    chk(w.cls, clsOf(op));
    chk(w.wide, wd);
    chk(w.addr, ea);
  endtask

  task automatic setBank(input logic [7:0] op, input logic [7:0] v);
    u_host.frame({48'h0, op, v}, 16, rx);
    pop(w);
    chk(w.cls, CLS_BANK_WR);
  endtask

  task automatic expectBank(input logic [7:0] v);
    chk(bankSel, v);
    fork
      u_host.frame({48'h0, 8'h16, 8'h00}, 16, rx);
      begin
        // well inside the data phase of the bank read
        repeat (100) @(negedge clk);
        chk({soOe, dataPhase}, 2'h3);
      end
    join
    chk(rx[7:0], v);
    pop(w);
    chk(w.cls, CLS_BANK_RD);
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    cmdReady = 1'b0;
    nErrors = 0;
    totalChecks = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk({cmdValid, cmdOverflow, soOe, dataPhase}, 4'h0);
    expectBank(8'h00);
    foreach (FIX[i])
      cmdAddr(FIX[i], 1'b1, 32'h02a4c6e8,
        32'h02a4c6e8);
    foreach (LEG[i])
      cmdAddr(LEG[i], 1'b0, 32'h3a5c7e,
        32'h3a5c7e);
    setBank(8'h17, 8'hff);
    expectBank(8'h83);
    setBank(8'h17, 8'h01);
    foreach (LEG[i])
      cmdAddr(LEG[i], 1'b0, 32'h3a5c7e,
        32'h013a5c7e);
    cmdAddr(8'h13, 1'b1, 32'h00001234, 32'h00001234);
    setBank(8'hb9, 8'h80);
    expectBank(8'h80);
    foreach (LEG[i])
      cmdAddr(LEG[i], 1'b1, 32'h02a4c6e8,
        32'h02a4c6e8);
    setBank(8'h17, 8'h01);
    // two data bytes read across the top of bank 1
    u_host.frame({16'h0, 8'h03, 24'hfffffe, 16'h0}, 48, rx);
    chk(curAddr, 32'h02000000);
    chk(bankSel, 8'h01);
    pop(w);
    chk(w.addr, 32'h01fffffe);
    foreach (MISC[i])
    begin
      u_host.frame({24'h0, MISC[i], 32'h0}, 40, rx);
      pop(w);
      chk(w.opcode, MISC[i]);
      chk(w.cls, clsOf(MISC[i]));
    end
    // unknown opcode followed by a bank write pattern
    u_host.frame({40'h0, 8'h77, 8'h17, 8'h80}, 24, rx);
    repeat (20) @(negedge clk);
    chk(cmdValid, 1'b0);
    chk(bankSel, 8'h01);
    // fill the queue with the consumer stalled, then drain it
    repeat (20) u_host.frame(64'h06, 8, rx);
    chk(cmdOverflow, 1'b1);
    k = 0;
    while (cmdValid === 1'b1 && k < 40)
    begin
      chk(cmdWord.opcode, 8'h06);
      cmdReady = 1'b1;
      @(negedge clk);
      cmdReady = 1'b0;
      @(negedge clk);
      k++;
    end
    // 16 queued words, the output register and the pending slot
    chk(k, 64'h12);
    chk(cmdOverflow, 1'b1);
    finalReport();
  end

  initial
  begin
    repeat (95000) @(posedge clk);
    chk(1'b0, 1'b1);
    finalReport();
  end
endmodule
